// ===== design/adp_pkg.sv
// Shared constants and types for the interrupt controller port block.
// Assumes a single 100 MHz clock domain and an 8-bit byte address per space.
package adp_pkg;

  // Number of interrupt inputs served by the redirection table.
  localparam int          NUM_IRQ          = 24;
  localparam logic [4:0]  IRQ_LAST         = 5'h17;

  // Direct memory space byte offsets.
  localparam logic [7:0]  OFF_INDEX        = 8'h00;
  localparam logic [7:0]  OFF_WINDOW       = 8'h10;
  localparam logic [7:0]  OFF_PIN_ASSERT   = 8'h20;
  localparam logic [7:0]  OFF_EOI          = 8'h40;

  // Configuration space offsets of the power capability.
  localparam logic [7:0]  OFF_PM_CAPID     = 8'h6c;
  localparam logic [7:0]  OFF_POWER_MGMT_CAPABILITIES       = 8'h6e;
  localparam logic [7:0]  OFF_PM_CTRL      = 8'h70;
  localparam logic [7:0]  POWER_MGMT_CAPABILITIES_ID        = 8'h01;
  localparam logic [7:0]  PM_NEXT_PTR      = 8'h00;
  localparam logic [15:0] POWER_MGMT_CAPABILITIES_VALUE     = 16'h0002;

  // Power state codes; the two others are reserved.
  localparam logic [1:0]  PWR_D0           = 2'h0;
  localparam logic [1:0]  PWR_D3HOT        = 2'h3;

  // Indirect register indices.
  localparam logic [7:0]  IND_APIC_ID      = 8'h00;
  localparam logic [7:0]  IND_VERSION      = 8'h01;
  localparam logic [7:0]  IND_ARB_ID       = 8'h02;
  localparam logic [7:0]  IND_BOOT_CFG     = 8'h03;
  localparam logic [7:0]  IND_REDIR_FIRST  = 8'h10;
  localparam logic [7:0]  IND_REDIR_LAST   = 8'h3f;

  // Indirect register contents and fields.
  localparam logic [31:0] VERSION_VALUE    = 32'h00178020;
  localparam int          APIC_ID_LSB      = 24;
  localparam logic        BOOT_CFG_RESET   = 1'h1;
  localparam logic [31:0] RDL_RESET        = 32'h00010000;
  localparam logic [31:0] RDH_RESET        = 32'h00000000;
  localparam logic [31:0] RDL_WMASK        = 32'h0003afff;
  localparam logic [31:0] RDH_WMASK        = 32'hffffffff;
  localparam int          RDL_REMOTE_BIT   = 14;
  localparam int          RDL_MASK_BIT     = 16;

  // Merge the enabled byte lanes of a write into an old word.
  function automatic logic [31:0] byte_merge(input logic [31:0] oldW, input logic [31:0] newW,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = oldW;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = newW[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Whole state of the front end.
  typedef struct packed {
    logic [7:0]         index;
    logic [1:0]         pwr;
    logic [3:0]         apicId;
    logic               bootDt;
    logic [4:0]         pinAssert;
    logic               rspValid;
    logic [31:0]        rspData;
    logic               reqDropped;
    logic               msgValid;
    logic [31:0]        msgLow;
    logic [31:0]        msgHigh;
    logic [NUM_IRQ-1:0] vwire;
  } adp_state_t;

  // Whole state of the redirection table.
  typedef struct packed {
    logic [NUM_IRQ-1:0][31:0] low;
    logic [NUM_IRQ-1:0][31:0] high;
  } adp_table_t;

endpackage

// ===== design/adp_redir_table.sv
// Redirection table: 24 low/high entry pairs with end-of-interrupt clearing.
// Assumes the front end qualifies writes and end-of-interrupt strobes.
`timescale 1ns/1ns
module adp_redir_table (
  input  wire logic                         clk,         // System clock.
  input  wire logic                         reset,       // Asynchronous, active high.
  input  wire logic [7:0]                   idx,         // Current indirect index.
  input  wire logic                         wrEn,        // Window write into the table.
  input  wire logic [3:0]                   wrBe,        // Byte lanes of that write.
  input  wire logic [31:0]                  wrData,      // Write data.
  output      logic                         inRange,     // Index addresses a table entry.
  output      logic [31:0]                  rdData,      // Dword selected by the index.
  input  wire logic [4:0]                   selIrq,      // Input picked by a pin assertion.
  output      logic [31:0]                  selLow,      // Its low dword.
  output      logic [31:0]                  selHigh,     // Its high dword.
  input  wire logic                         eoiEn,       // End-of-interrupt strobe.
  input  wire logic [7:0]                   eoiVector,   // Vector to clear.
  input  wire logic [adp_pkg::NUM_IRQ-1:0]  remoteSet    // Level delivery accepted per input.
);
  import adp_pkg::*;

  adp_table_t  q;                       // Registered table.
  adp_table_t  d;                       // Next table.
  logic [7:0]  rel;                     // Index relative to the first entry.
  logic [4:0]  entry;                   // Entry number selected by the index.
  logic        hiSel;                   // Odd index selects the high dword.
  logic [31:0] lowNext  [NUM_IRQ];      // Per-entry next low dword.
  logic [31:0] highNext [NUM_IRQ];      // Per-entry next high dword.

  assign rel     = idx - IND_REDIR_FIRST;
  assign entry   = rel[5:1];
  assign hiSel   = rel[0];
  assign inRange = (idx >= IND_REDIR_FIRST) && (idx <= IND_REDIR_LAST);
  assign rdData  = hiSel ? q.high[entry] : q.low[entry];
  assign selLow  = q.low[selIrq];
  assign selHigh = q.high[selIrq];

  // Each entry compares its own vector, so every match clears at once.
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_ent
    logic hit;                          // This entry is the window target.
    logic eoiHit;                       // End of interrupt names this vector.
    assign hit    = wrEn && inRange && (entry == 5'(i));
    assign eoiHit = eoiEn && (q.low[i][7:0] == eoiVector);

    // Read-only bits keep their value; a new delivery wins over a clear in the same cycle.
    always_comb begin
      lowNext[i] = q.low[i];
      if (hit && !hiSel) begin
        lowNext[i] = (q.low[i] & ~RDL_WMASK) | (byte_merge(q.low[i], wrData, wrBe) & RDL_WMASK);
      end
      if (eoiHit) begin
        lowNext[i][RDL_REMOTE_BIT] = 1'b0;
      end
      if (remoteSet[i]) begin
        lowNext[i][RDL_REMOTE_BIT] = 1'b1;
      end
      highNext[i] = q.high[i];
      if (hit && hiSel) begin
        highNext[i] = (q.high[i] & ~RDH_WMASK) | (byte_merge(q.high[i], wrData, wrBe) & RDH_WMASK);
      end
    end

    a_eoi_clear_each: assert property (@(posedge clk) disable iff (reset)
      (eoiHit && !remoteSet[i]) |=> !q.low[i][RDL_REMOTE_BIT])
      else $error("matching entry kept its pending flag after end of interrupt");
  end

  // Gather the per-entry values into the next state.
  always_comb begin
    d = q;
    for (int k = 0; k < NUM_IRQ; k++) begin
      d.low[k]  = lowNext[k];
      d.high[k] = highNext[k];
    end
  end

  // Table storage; the power state never touches it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < NUM_IRQ; k++) begin
        q.low[k]  <= RDL_RESET;
        q.high[k] <= RDH_RESET;
      end
    end else begin
      q <= d;
    end
  end

  c_eoi_clear: cover property (@(posedge clk) disable iff (reset) eoiEn && (g_ent[0].eoiHit));

endmodule // adp_redir_table

// ===== design/adp_apic_port.sv
// Front end of the interrupt controller function: power capability in
// configuration space and the index/window/pin-assert/end-of-interrupt
// registers in memory space.
// Assumes one request per cycle on a simple synchronous request port and a
// separate message delivery stage that reports accepted level deliveries.
`timescale 1ns/1ns

module adp_apic_port (
  input  wire logic                         clk,          // System clock, 100 MHz.
  input  wire logic                         reset,        // Asynchronous, active high.
  input  wire logic                         reqValid,     // A request is offered this cycle.
  input  wire logic                         reqIsCfg,     // Request is a configuration access.
  input  wire logic                         reqWrite,     // Write when high, read when low.
  input  wire logic [7:0]                   reqAddr,      // Byte address within the space.
  input  wire logic [3:0]                   reqByteEn,    // Byte lanes of the dword.
  input  wire logic [31:0]                  reqWdata,     // Write data, lane aligned.
  output      logic                         rspValid,     // Request completed, one cycle.
  output      logic [31:0]                  rspData,      // Read data of the completion.
  output      logic                         reqDropped,   // Request ignored in D3hot, one cycle.
  output      logic                         msgValid,     // Interrupt message, one cycle.
  output      logic [31:0]                  msgLow,       // Message low dword.
  output      logic [31:0]                  msgHigh,      // Message high dword.
  input  wire logic [adp_pkg::NUM_IRQ-1:0]  remoteSet,    // Level delivery accepted per input.
  input  wire logic [adp_pkg::NUM_IRQ-1:0]  vwireIn,      // Virtual wire levels from agents.
  output      logic [adp_pkg::NUM_IRQ-1:0]  vwireOut,     // Forwarded virtual wire levels.
  output      logic [1:0]                   powerState    // Current power state field.
);
  import adp_pkg::*;

  adp_state_t  q;              // Registered state.
  adp_state_t  d;              // Next state.
  logic        inD3;           // Function sits in D3hot.
  logic        accepted;       // Request is served this cycle.
  logic        memWrite;       // Served memory write.
  logic        memRead;        // Served memory read.
  logic        hitWindow;      // Address falls on the window dword.
  logic        tableWrEn;      // Window write reaches the table.
  logic        tableInRange;   // Index points into the table.
  logic [31:0] tableRdData;    // Table dword under the index.
  logic [31:0] windowRd;       // Whatever the window shows now.
  logic [4:0]  selIrq;         // Input named by a pin assertion write.
  logic [31:0] selLow;         // Low dword of that input's entry.
  logic [31:0] selHigh;        // High dword of that input's entry.
  logic        parValid;       // Pin assertion carries a legal input.
  logic        eoiEn;          // End-of-interrupt write this cycle.

  // Memory requests are refused outright in D3hot; configuration always passes.
  assign inD3      = (q.pwr == PWR_D3HOT);
  assign accepted  = reqValid && (reqIsCfg || !inD3);
  assign memWrite  = accepted && !reqIsCfg && reqWrite;
  assign memRead   = accepted && !reqIsCfg && !reqWrite;
  assign hitWindow = (reqAddr[7:2] == OFF_WINDOW[7:2]);

  // The window follows the index set beforehand.
  assign tableWrEn = memWrite && hitWindow;

  // The selected input is the low field of the written data.
  assign selIrq    = reqWdata[4:0];
  assign parValid  = (selIrq <= IRQ_LAST);

  // Only a write at the end-of-interrupt offset that enables lane zero counts; the vector sits in that lane.
  assign eoiEn     = memWrite && (reqAddr[7:2] == OFF_EOI[7:2]) && reqByteEn[0];

  // Mux of the indirect registers that live outside the table.
  always_comb begin
    windowRd = 32'h00000000;
    if (tableInRange) begin
      windowRd = tableRdData;
    end else begin
      case (q.index)
        IND_APIC_ID:  windowRd[APIC_ID_LSB +: 4] = q.apicId;
        IND_VERSION:  windowRd = VERSION_VALUE;
        IND_ARB_ID:   windowRd[APIC_ID_LSB +: 4] = q.apicId;
        IND_BOOT_CFG: windowRd[0] = q.bootDt;
        default:      windowRd = 32'h00000000;
      endcase
    end
  end

  // Table of redirection entries; remote flags and vectors live there.
  adp_redir_table u_table (
    .clk       (clk),
    .reset     (reset),
    .idx       (q.index),
    .wrEn      (tableWrEn),
    .wrBe      (reqByteEn),
    .wrData    (reqWdata),
    .inRange   (tableInRange),
    .rdData    (tableRdData),
    .selIrq    (selIrq),
    .selLow    (selLow),
    .selHigh   (selHigh),
    .eoiEn     (eoiEn),
    .eoiVector (reqWdata[7:0]),
    .remoteSet (remoteSet)
  );

  // Next-state logic for the whole front end.
  always_comb begin
    d            = q;
    d.rspValid   = 1'b0;
    d.reqDropped = 1'b0;
    d.msgValid   = 1'b0;
    // Virtual wires pass in every power state.
    d.vwire      = vwireIn;
    if (reqValid && !accepted) begin
      // No completion at all; the requester sees only the drop pulse.
      d.reqDropped = 1'b1;
    end else if (accepted) begin
      d.rspValid = 1'b1;
      d.rspData  = 32'h00000000;
      if (reqIsCfg) begin
        case (reqAddr[7:2])
          OFF_PM_CAPID[7:2]: begin
            // Identifier, next pointer and the fixed capability word share one dword.
            d.rspData = {POWER_MGMT_CAPABILITIES_VALUE, PM_NEXT_PTR, POWER_MGMT_CAPABILITIES_ID};
          end
          OFF_PM_CTRL[7:2]: begin
            d.rspData[1:0] = q.pwr;
            // Reserved codes still complete but leave the state alone.
            if (reqWrite && reqByteEn[0] &&
                ((reqWdata[1:0] == PWR_D0) || (reqWdata[1:0] == PWR_D3HOT))) begin
              d.pwr = reqWdata[1:0];
            end
          end
          default: begin
            d.rspData = 32'h00000000;
          end
        endcase
      end else begin
        case (reqAddr[7:2])
          OFF_INDEX[7:2]: begin
            d.rspData[7:0] = q.index;
            if (reqWrite && reqByteEn[0]) begin
              d.index = reqWdata[7:0];
            end
          end
          OFF_WINDOW[7:2]: begin
            d.rspData = windowRd;
            // Only the APIC ID and delivery type are writable outside the table.
            if (reqWrite && (q.index == IND_APIC_ID) && reqByteEn[3]) begin
              d.apicId = reqWdata[APIC_ID_LSB +: 4];
            end
            if (reqWrite && (q.index == IND_BOOT_CFG) && reqByteEn[0]) begin
              d.bootDt = reqWdata[0];
            end
          end
          OFF_PIN_ASSERT[7:2]: begin
            d.rspData[4:0] = q.pinAssert;
            if (reqWrite && reqByteEn[0]) begin
              d.pinAssert = selIrq;
              // Every write is an edge: the entry's trigger mode is not consulted and
              // no pending flag is set, so repeated writes each yield a message.
              if (parValid && !selLow[RDL_MASK_BIT] && !inD3) begin
                d.msgValid = 1'b1;
                d.msgLow   = selLow;
                d.msgHigh  = selHigh;
              end
            end
          end
          default: begin
            // End of interrupt is write only and unmapped offsets read as zero.
            d.rspData = 32'h00000000;
          end
        endcase
      end
    end
  end

  // State register; nothing here looks at the power state on reset or exit.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q            <= '0;
      q.index      <= 8'h00;
      q.pwr        <= PWR_D0;
      q.bootDt     <= BOOT_CFG_RESET;
    end else begin
      q <= d;
    end
  end

  assign rspValid   = q.rspValid;
  assign rspData    = q.rspData;
  assign reqDropped = q.reqDropped;
  assign msgValid   = q.msgValid;
  assign msgLow     = q.msgLow;
  assign msgHigh    = q.msgHigh;
  assign vwireOut   = q.vwire;
  assign powerState = q.pwr;

  // Checks on the registered behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pm_version: assert property (
    (reqValid && reqIsCfg && !reqWrite && (reqAddr[7:2] == OFF_PM_CAPID[7:2]))
      |=> rspValid && (rspData[18:16] == 3'h2))
    else $error("power capability version read back wrong");

  a_pwr_legal: assert property (
    (powerState == PWR_D0) || (powerState == PWR_D3HOT))
    else $error("power state holds a reserved code");

  a_pwr_drop: assert property (
    (reqValid && reqIsCfg && reqWrite && (reqAddr[7:2] == OFF_PM_CTRL[7:2]) &&
     ((reqWdata[1:0] == 2'h1) || (reqWdata[1:0] == 2'h2)))
      |=> rspValid && $stable(powerState))
    else $error("reserved power code changed state or did not complete");

  a_d3_ignore: assert property (
    (reqValid && !reqIsCfg && (powerState == PWR_D3HOT)) |=> reqDropped && !rspValid)
    else $error("memory request served in D3hot");

  a_d3_exit_keep: assert property (
    ((powerState == PWR_D0) && ($past(powerState) == PWR_D3HOT))
      |-> (q.index == $past(q.index)) && (q.apicId == $past(q.apicId)))
    else $error("registers changed on leaving D3hot");

  a_d3_no_msg: assert property (
    msgValid |-> (powerState == PWR_D0))
    else $error("interrupt message emitted in D3hot");

  a_vwire_pass: assert property (
    ##1 (vwireOut == $past(vwireIn)))
    else $error("virtual wire not forwarded");

  a_window_read: assert property (
    (memRead && hitWindow && tableInRange) |=> rspValid && (rspData == $past(tableRdData)))
    else $error("window read returned wrong table dword");

  a_par_msg: assert property (
    (memWrite && (reqAddr[7:2] == OFF_PIN_ASSERT[7:2]) && reqByteEn[0] && parValid &&
     !selLow[RDL_MASK_BIT])
      |=> msgValid && (msgLow == $past(selLow)) && (msgHigh == $past(selHigh)))
    else $error("pin assertion message wrong or missing");

  a_par_range: assert property (
    (reqValid && !reqIsCfg && reqWrite && (reqAddr[7:2] == OFF_PIN_ASSERT[7:2]) && !parValid)
      |=> !msgValid)
    else $error("out-of-range pin assertion produced a message");

  c_enter_d3: cover property ((powerState == PWR_D0) ##1 (powerState == PWR_D3HOT));
  c_par_msg:  cover property (msgValid);
  c_d3_drop:  cover property (reqDropped);
  c_d3_back:  cover property ((powerState == PWR_D3HOT) ##1 (powerState == PWR_D0));

endmodule // adp_apic_port

// ===== test/adp_host_model.sv
// Host model that issues register requests to the interrupt controller port.
// Assumes the block's answer is visible just after the edge that takes a request.
`timescale 1ns/1ns
module adp_host_model (
  input  wire logic        clk,        // System clock.
  output      logic        reqValid,   // Request strobe.
  output      logic        reqIsCfg,   // Configuration space select.
  output      logic        reqWrite,   // Write when high.
  output      logic [7:0]  reqAddr,    // Byte address.
  output      logic [3:0]  reqByteEn,  // Byte lanes.
  output      logic [31:0] reqWdata,   // Write data.
  input  wire logic        rspValid,   // Completion pulse.
  input  wire logic [31:0] rspData,    // Read data.
  input  wire logic        reqDropped  // Ignored request pulse.
);
  // Idle values at time zero.
  initial begin
    reqValid = 1'b0;
    reqIsCfg = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 8'h00;
    reqByteEn = 4'h0;
    reqWdata = 32'h00000000;
  end

  // One request, held through the taking edge; the answer is read once that edge has landed.
  // Released data is inverted so a stale value is never mistaken for fresh data.
  task automatic access(input logic cfg, input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] rd, output logic ok, output logic drop);
    @(posedge clk);
    reqValid <= 1'b1;
    reqIsCfg <= cfg;
    reqWrite <= wr;
    reqAddr <= a;
    reqByteEn <= be;
    reqWdata <= d;
    @(posedge clk);
    reqValid <= 1'b0;
    reqWdata <= ~d;
    #1;
    rd = rspData;
    ok = rspValid;
    drop = reqDropped;
  endtask
endmodule // adp_host_model

// ===== test/tb.sv
// Self-checking bench for the interrupt controller port block.
// Assumes the host model drives the request port and this bench drives the side inputs.
`timescale 1ns/1ns
module tb;
  import adp_pkg::*;
  logic              clk = 1'b0;   // 100 MHz clock.
  logic              reset = 1'b1; // Active high reset.
  logic              reqValid, reqIsCfg, reqWrite, rspValid, reqDropped, msgValid, ok, drop;
  logic [7:0]        reqAddr;      // Request address.
  logic [3:0]        reqByteEn;    // Request lanes.
  logic [31:0]       reqWdata, rspData, msgLow, msgHigh, rd;
  logic [NUM_IRQ-1:0] remoteSet = '0; // Accepted level deliveries.
  logic [NUM_IRQ-1:0] vwireIn = '0;   // Virtual wire levels in.
  logic [NUM_IRQ-1:0] vwireOut;       // Forwarded levels.
  logic [1:0]        powerState;   // Current power state.
  int                num_errors = 0;
  int                checked = 0;

  // Free running clock.
  always #5 clk = ~clk;

  adp_host_model adp_host_model_i (.clk(clk), .reqValid(reqValid), .reqIsCfg(reqIsCfg), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqWdata(reqWdata), .rspValid(rspValid), .rspData(rspData),
    .reqDropped(reqDropped));
  adp_apic_port adp_apic_port_i (.clk(clk), .reset(reset), .reqValid(reqValid), .reqIsCfg(reqIsCfg),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqWdata(reqWdata), .rspValid(rspValid),
    .rspData(rspData), .reqDropped(reqDropped), .msgValid(msgValid), .msgLow(msgLow), .msgHigh(msgHigh),
    .remoteSet(remoteSet), .vwireIn(vwireIn), .vwireOut(vwireOut), .powerState(powerState));

  // Compare a word result.
  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Compare a flag result.
  task automatic check_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  // One request without checks.
  task automatic xfer(input logic cfg, input logic wr, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
    adp_host_model_i.access(cfg, wr, a, be, d, rd, ok, drop);
  endtask

  // A read that must complete with the given data.
  task automatic rdchk(input logic cfg, input logic [7:0] a, input logic [31:0] e);
    xfer(cfg, 1'b0, a, 4'hf, 32'h00000000);
    check_bit("completion", 1'b1, ok);
    check_word("read data", e, rd);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    #50000;
    num_errors++;
    conclude();
  end

  // Main test sequence.
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rdchk(1'b0, OFF_INDEX, 32'h00000000);
    rdchk(1'b1, OFF_PM_CAPID, 32'h00020001);
    rdchk(1'b1, OFF_PM_CTRL, 32'h00000000);
    $display("test reset values done");
    xfer(1'b0, 1'b1, OFF_INDEX, 4'h1, 32'h00000001);
    rdchk(1'b0, OFF_WINDOW, 32'h00178020);
    xfer(1'b0, 1'b1, OFF_INDEX, 4'h1, 32'h00000010);
    xfer(1'b0, 1'b1, OFF_WINDOW, 4'hf, 32'h00000041);
    xfer(1'b0, 1'b1, OFF_WINDOW, 4'h2, 32'hffff02ff);
    rdchk(1'b0, OFF_WINDOW, 32'h00000241);
    xfer(1'b0, 1'b1, OFF_INDEX, 4'h1, 32'h0000003e);
    xfer(1'b0, 1'b1, OFF_WINDOW, 4'hf, 32'h00000041);
    xfer(1'b0, 1'b1, OFF_INDEX, 4'h1, 32'h0000003f);
    xfer(1'b0, 1'b1, OFF_WINDOW, 4'hf, 32'haa000000);
    $display("test window done");
    xfer(1'b0, 1'b1, OFF_PIN_ASSERT, 4'h1, 32'h00000017);
    check_bit("message", 1'b1, msgValid);
    check_word("message low", 32'h00000041, msgLow);
    check_word("message high", 32'haa000000, msgHigh);
    // A repeated write is a fresh edge and must raise a second message.
    xfer(1'b0, 1'b1, OFF_PIN_ASSERT, 4'h1, 32'h00000017);
    check_bit("message repeat", 1'b1, msgValid);
    xfer(1'b0, 1'b1, OFF_PIN_ASSERT, 4'h1, 32'h00000018);
    check_bit("message", 1'b0, msgValid);
    rdchk(1'b0, OFF_PIN_ASSERT, 32'h00000018);
    $display("test pin assertion done");
    @(posedge clk);
    remoteSet <= 24'h800001;
    @(posedge clk);
    remoteSet <= 24'h000000;
    xfer(1'b0, 1'b1, OFF_INDEX, 4'h1, 32'h00000010);
    rdchk(1'b0, OFF_WINDOW, 32'h00004241);
    xfer(1'b0, 1'b1, OFF_EOI, 4'h1, 32'h00000041);
    rdchk(1'b0, OFF_WINDOW, 32'h00000241);
    xfer(1'b0, 1'b1, OFF_INDEX, 4'h1, 32'h0000003e);
    rdchk(1'b0, OFF_WINDOW, 32'h00000041);
    $display("test end of interrupt done");
    xfer(1'b1, 1'b1, OFF_PM_CTRL, 4'h1, 32'h00000003);
    check_word("power state", 32'h00000003, {30'h0, powerState});
    xfer(1'b1, 1'b1, OFF_PM_CTRL, 4'h1, 32'h00000001);
    check_bit("completion", 1'b1, ok);
    check_word("power state", 32'h00000003, {30'h0, powerState});
    xfer(1'b0, 1'b0, OFF_INDEX, 4'hf, 32'h00000000);
    check_bit("dropped", 1'b1, drop);
    check_bit("completion", 1'b0, ok);
    xfer(1'b0, 1'b1, OFF_PIN_ASSERT, 4'h1, 32'h00000017);
    check_bit("message", 1'b0, msgValid);
    vwireIn <= 24'h5a5a5a;
    repeat (2) @(posedge clk);
    #1;
    check_word("virtual wires", 32'h005a5a5a, {8'h00, vwireOut});
    xfer(1'b1, 1'b1, OFF_PM_CTRL, 4'h1, 32'h00000000);
    rdchk(1'b0, OFF_INDEX, 32'h0000003e);
    rdchk(1'b0, OFF_WINDOW, 32'h00000041);
    $display("test power states done");
    conclude();
  end
endmodule // tb
